// File: rtl/psf_pkg.sv
// psf_pkg: constants and types of the packet/stream framer
`default_nettype none

package psf_pkg;

    // --------
    // frame layout
    // --------
    localparam logic [6:0] PRE_BYTES = 7'h04;
    localparam logic [7:0] PRE_BYTE = 8'h00;
    localparam logic [7:0] SFD_BYTE = 8'ha7;
    localparam logic [6:0] MAX_PAYLOAD = 7'h7d;
    localparam logic [6:0] FCS_BYTES = 7'h02;
    localparam logic [6:0] LQI_ADDR = 7'h7f;
    localparam int RAM_DEPTH = 128;

    // --------
    // check sequence: reflected x^16+x^12+x^5+1, zero start
    // --------
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    // --------
    // timing
    // --------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int LQI_US = 64;
    localparam int CCA_US = 128;
    localparam int LQI_CYCLES = LQI_US * 1000000 / CLK_PERIOD_PS;
    localparam int CCA_CYCLES = CCA_US * 1000000 / CLK_PERIOD_PS;

    // --------
    // types
    // --------
    typedef enum {TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_PAY, TX_FCS0, TX_FCS1, TX_DRAIN} psf_tx_st_t;
    typedef enum {RX_HUNT, RX_LEN, RX_PAY, RX_LQI} psf_rx_st_t;

    typedef struct packed {
        logic tx_req;
        logic rx_word;
        logic tx_done;
        logic rx_done;
    } psf_cause_t;

    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } psf_ram_wr_t;

endpackage : psf_pkg

`default_nettype wire

// File: rtl/psf_framer.sv
// psf_framer: frame build/parse, packet and stream transfer, link crossing
`default_nettype none

// What this block does
// - packet mode keeps whole frames in RAM
// - stream mode moves one word at a time
// - payload limited to 125 bytes
// - transmit preamble, start delimiter, length first
// - transmit appends two-byte check sequence
// - receive parses header, stores payload and check in packet mode
// - receive checks sequence, reports pass or fail
// - link quality over 64 us after preamble
// - packet receive interrupts once per frame
// - stream receive interrupts per word
// - transmit request sends buffered frame in packet mode
// - packet transmit interrupts when frame sent
// - stream transmit interrupts before each word, to request it
// - channel assessment integrates energy, reports level
module psf_framer #(
    parameter int LQI_CYCLES = psf_pkg::LQI_CYCLES,
    parameter int CCA_CYCLES = psf_pkg::CCA_CYCLES
) (
    // clocks and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    // host control
    input wire logic stream_mode_i,
    input wire psf_pkg::psf_ram_wr_t tx_wr_i,
    input wire logic [6:0] tx_len_i,
    input wire logic tx_go_i,
    output logic tx_busy_o,
    // host stream transmit
    input wire logic [7:0] tx_word_i,
    input wire logic tx_word_valid_i,
    output logic tx_word_ready_o,
    // host receive
    input wire logic [6:0] rx_rd_addr_i,
    output logic [7:0] rx_rd_data_o,
    output logic [7:0] rx_word_o,
    output logic rx_word_valid_o,
    output logic [6:0] rx_len_o,
    output logic crc_ok_o,
    output logic [7:0] lqi_o,
    // channel assessment
    input wire logic [7:0] energy_i,
    input wire logic cca_start_i,
    output logic cca_busy_o,
    output logic [7:0] cca_level_o,
    // interrupt
    input wire psf_pkg::psf_cause_t cause_clr_i,
    output psf_pkg::psf_cause_t cause_o,
    output logic irq_o,
    // link side, on link_clk_i
    output logic [7:0] link_tx_data_o,
    output logic link_tx_valid_o,
    input wire logic link_tx_ready_i,
    input wire logic [7:0] link_rx_data_i,
    input wire logic link_rx_valid_i
);

    // --------
    // declarations
    // --------
    logic [7:0] tx_ram [psf_pkg::RAM_DEPTH];
    logic [7:0] rx_ram [psf_pkg::RAM_DEPTH];
    logic [7:0] fb_mem_q [2];
    logic [7:0] fb_mem_d [2];
    logic [7:0] int_lvl [2];
    psf_pkg::psf_tx_st_t tx_st_q, tx_st_d;
    psf_pkg::psf_rx_st_t rx_st_q, rx_st_d;
    psf_pkg::psf_cause_t cause_q, cause_d, ev;
    logic [15:0] tx_crc_q, tx_crc_d, rx_crc_q, rx_crc_d;
    logic [6:0] tx_cnt_q, tx_cnt_d, tx_len_q, tx_len_d, ram_wa, rx_cnt_q, rx_cnt_d;
    logic [6:0] rx_len_q, rx_len_d, zc_q, zc_d, rx_lenf_q, rx_lenf_d;
    logic [7:0] fb_in_data, tx_hold_q, tx_hold_d, ltx_data_q, ltx_data_d, lrx_hold_q, lrx_hold_d;
    logic [7:0] rxw_q, rxw_d, rd_q, ram_wd;
    logic [1:0] fb_cnt_q, fb_cnt_d, int_busy;
    logic tx_strm_q, tx_strm_d, rx_strm_q, rx_strm_d, fb_in_valid, fb_in_ready, fb_out_valid;
    logic fb_pop, fb_wp_q, fb_wp_d, fb_rp_q, fb_rp_d, tx_req_q, tx_req_d, tx_ack_s1, tx_ack_s2;
    logic cdc_idle, ltx_req_s1, ltx_req_s2, ltx_ack_q, ltx_ack_d, ltx_valid_q, ltx_valid_d;
    logic lrx_tgl_q, lrx_tgl_d, rx_tgl_s1, rx_tgl_s2, rx_tgl_s3, rx_ev, lqi_start, cca_start;
    logic crc_ok_q, crc_ok_d, rxw_v_q, rxw_v_d, ram_we;

    function automatic logic [15:0] psf_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ (((r[0] ^ b[i]) == 1'b1) ? psf_pkg::CRC_POLY : 16'h0000);
        end
        return r;
    endfunction : psf_crc

    // --------
    // transmit framer
    // --------
    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_len_d = tx_len_q;
        tx_crc_d = tx_crc_q;
        tx_strm_d = tx_strm_q;
        fb_in_valid = 1'b0;
        fb_in_data = 8'h00;
        tx_word_ready_o = 1'b0;
        ev.tx_req = 1'b0;
        ev.tx_done = 1'b0;
        case (tx_st_q)
            psf_pkg::TX_IDLE: begin
                if (tx_go_i && tx_len_i <= psf_pkg::MAX_PAYLOAD) begin
                    tx_st_d = psf_pkg::TX_PRE;
                    tx_cnt_d = 7'h00;
                    tx_len_d = tx_len_i;
                    tx_crc_d = psf_pkg::CRC_INIT;
                    tx_strm_d = stream_mode_i;
                end
            end
            psf_pkg::TX_PRE: begin
                fb_in_valid = 1'b1;
                fb_in_data = psf_pkg::PRE_BYTE;
                if (fb_in_ready) begin
                    tx_cnt_d = tx_cnt_q + 7'h01;
                    if (tx_cnt_q == psf_pkg::PRE_BYTES - 7'h01) begin
                        tx_st_d = psf_pkg::TX_SFD;
                    end
                end
            end
            psf_pkg::TX_SFD: begin
                fb_in_valid = 1'b1;
                fb_in_data = psf_pkg::SFD_BYTE;
                if (fb_in_ready) begin
                    tx_st_d = psf_pkg::TX_LEN;
                end
            end
            psf_pkg::TX_LEN: begin
                fb_in_valid = 1'b1;
                fb_in_data = {1'b0, tx_len_q + psf_pkg::FCS_BYTES};
                if (fb_in_ready) begin
                    tx_cnt_d = 7'h00;
                    tx_st_d = (tx_len_q == 7'h00) ? psf_pkg::TX_FCS0 : psf_pkg::TX_PAY;
                    ev.tx_req = tx_strm_q && tx_len_q != 7'h00;
                end
            end
            psf_pkg::TX_PAY: begin
                if (tx_strm_q) begin
                    fb_in_valid = tx_word_valid_i;
                    fb_in_data = tx_word_i;
                    tx_word_ready_o = fb_in_ready;
                end else begin
                    fb_in_valid = 1'b1;
                    fb_in_data = tx_ram[tx_cnt_q];
                end
                if (fb_in_valid && fb_in_ready) begin
                    tx_crc_d = psf_crc(tx_crc_q, fb_in_data);
                    tx_cnt_d = tx_cnt_q + 7'h01;
                    if (tx_cnt_q == tx_len_q - 7'h01) begin
                        tx_st_d = psf_pkg::TX_FCS0;
                    end else begin
                        ev.tx_req = tx_strm_q;
                    end
                end
            end
            psf_pkg::TX_FCS0: begin
                fb_in_valid = 1'b1;
                fb_in_data = tx_crc_q[7:0];
                if (fb_in_ready) begin
                    tx_st_d = psf_pkg::TX_FCS1;
                end
            end
            psf_pkg::TX_FCS1: begin
                fb_in_valid = 1'b1;
                fb_in_data = tx_crc_q[15:8];
                if (fb_in_ready) begin
                    tx_st_d = psf_pkg::TX_DRAIN;
                end
            end
            psf_pkg::TX_DRAIN: begin
                if (!fb_out_valid && cdc_idle) begin
                    tx_st_d = psf_pkg::TX_IDLE;
                    ev.tx_done = 1'b1;
                end
            end
            default: tx_st_d = psf_pkg::TX_IDLE;
        endcase
    end

    // --------
    // two-entry buffer and core side of the crossing
    // --------
    assign fb_in_ready = fb_cnt_q != 2'h2;
    assign fb_out_valid = fb_cnt_q != 2'h0;
    assign cdc_idle = tx_req_q == tx_ack_s2;
    assign fb_pop = fb_out_valid && cdc_idle;

    always_comb begin
        fb_mem_d = fb_mem_q;
        fb_wp_d = fb_wp_q;
        fb_rp_d = fb_rp_q;
        fb_cnt_d = fb_cnt_q;
        tx_req_d = tx_req_q;
        tx_hold_d = tx_hold_q;
        if (fb_in_valid && fb_in_ready) begin
            fb_mem_d[fb_wp_q] = fb_in_data;
            fb_wp_d = ~fb_wp_q;
        end
        if (fb_pop) begin
            tx_hold_d = fb_mem_q[fb_rp_q];
            tx_req_d = ~tx_req_q;
            fb_rp_d = ~fb_rp_q;
        end
        fb_cnt_d = fb_cnt_q + {1'b0, fb_in_valid && fb_in_ready} - {1'b0, fb_pop};
    end

    // --------
    // link domain
    // --------
    always_comb begin
        ltx_valid_d = ltx_valid_q;
        ltx_data_d = ltx_data_q;
        ltx_ack_d = ltx_ack_q;
        lrx_tgl_d = lrx_tgl_q;
        lrx_hold_d = lrx_hold_q;
        if (ltx_valid_q && link_tx_ready_i) begin
            ltx_valid_d = 1'b0;
            ltx_ack_d = ~ltx_ack_q;
        end else if (!ltx_valid_q && ltx_req_s2 != ltx_ack_q) begin
            ltx_valid_d = 1'b1;
            ltx_data_d = tx_hold_q;
        end
        if (link_rx_valid_i) begin
            lrx_hold_d = link_rx_data_i;
            lrx_tgl_d = ~lrx_tgl_q;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ltx_req_s1 <= 1'b0;
            ltx_req_s2 <= 1'b0;
            ltx_ack_q <= 1'b0;
            ltx_valid_q <= 1'b0;
            ltx_data_q <= 8'h00;
            lrx_tgl_q <= 1'b0;
            lrx_hold_q <= 8'h00;
        end else begin
            ltx_req_s1 <= tx_req_q;
            ltx_req_s2 <= ltx_req_s1;
            ltx_ack_q <= ltx_ack_d;
            ltx_valid_q <= ltx_valid_d;
            ltx_data_q <= ltx_data_d;
            lrx_tgl_q <= lrx_tgl_d;
            lrx_hold_q <= lrx_hold_d;
        end
    end

    assign link_tx_data_o = ltx_data_q;
    assign link_tx_valid_o = ltx_valid_q;
    assign rx_ev = rx_tgl_s2 ^ rx_tgl_s3;

    // --------
    // receive parser
    // --------
    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_len_d = rx_len_q;
        rx_lenf_d = rx_lenf_q;
        rx_crc_d = rx_crc_q;
        rx_strm_d = rx_strm_q;
        zc_d = zc_q;
        crc_ok_d = crc_ok_q;
        rxw_d = rxw_q;
        rxw_v_d = 1'b0;
        lqi_start = 1'b0;
        ram_we = 1'b0;
        ram_wa = rx_cnt_q;
        ram_wd = lrx_hold_q;
        ev.rx_word = 1'b0;
        ev.rx_done = 1'b0;
        case (rx_st_q)
            psf_pkg::RX_HUNT: begin
                if (rx_ev) begin
                    zc_d = 7'h00;
                    if (lrx_hold_q == psf_pkg::PRE_BYTE) begin
                        zc_d = (zc_q == psf_pkg::PRE_BYTES) ? zc_q : zc_q + 7'h01;
                    end else if (lrx_hold_q == psf_pkg::SFD_BYTE && zc_q == psf_pkg::PRE_BYTES) begin
                        rx_st_d = psf_pkg::RX_LEN;
                        lqi_start = 1'b1;
                    end
                end
            end
            psf_pkg::RX_LEN: begin
                if (rx_ev) begin
                    rx_st_d = psf_pkg::RX_HUNT;
                    if (!lrx_hold_q[7] && lrx_hold_q[6:0] >= psf_pkg::FCS_BYTES
                        && lrx_hold_q[6:0] <= psf_pkg::MAX_PAYLOAD + psf_pkg::FCS_BYTES) begin
                        rx_st_d = psf_pkg::RX_PAY;
                        rx_lenf_d = lrx_hold_q[6:0];
                        rx_cnt_d = 7'h00;
                        rx_crc_d = psf_pkg::CRC_INIT;
                        rx_strm_d = stream_mode_i;
                    end
                end
            end
            psf_pkg::RX_PAY: begin
                if (rx_ev) begin
                    rx_crc_d = psf_crc(rx_crc_q, lrx_hold_q);
                    ram_we = !rx_strm_q;
                    rx_cnt_d = rx_cnt_q + 7'h01;
                    if (rx_strm_q && rx_cnt_q < rx_lenf_q - psf_pkg::FCS_BYTES) begin
                        rxw_d = lrx_hold_q;
                        rxw_v_d = 1'b1;
                        ev.rx_word = 1'b1;
                    end
                    if (rx_cnt_q == rx_lenf_q - 7'h01) begin
                        rx_st_d = psf_pkg::RX_LQI;
                    end
                end
            end
            psf_pkg::RX_LQI: begin
                if (!int_busy[0]) begin
                    ram_we = 1'b1;
                    ram_wa = psf_pkg::LQI_ADDR;
                    ram_wd = int_lvl[0];
                    rx_len_d = rx_lenf_q - psf_pkg::FCS_BYTES;
                    crc_ok_d = rx_crc_q == psf_pkg::CRC_GOOD;
                    ev.rx_done = 1'b1;
                    rx_st_d = psf_pkg::RX_HUNT;
                end
            end
            default: rx_st_d = psf_pkg::RX_HUNT;
        endcase
    end

    // --------
    // energy integrators: 0 link quality, 1 channel assessment
    // --------
    assign cca_start = cca_start_i && !int_busy[1];

    for (genvar g = 0; g < 2; g++) begin : g_int
        localparam int N = (g == 0) ? LQI_CYCLES : CCA_CYCLES;
        localparam int SH = $clog2(N);
        logic [31:0] acc_q, acc_d, cnt_q, cnt_d;
        logic busy_q, busy_d;
        logic [7:0] lvl_q, lvl_d;
        always_comb begin
            acc_d = acc_q;
            cnt_d = cnt_q;
            busy_d = busy_q;
            lvl_d = lvl_q;
            if ((g == 0) ? lqi_start : cca_start) begin
                acc_d = 32'h0000_0000;
                cnt_d = 32'h0000_0000;
                busy_d = 1'b1;
            end else if (busy_q) begin
                acc_d = acc_q + {24'h00_0000, energy_i};
                cnt_d = cnt_q + 32'h0000_0001;
                if (cnt_q == 32'(N - 1)) begin
                    busy_d = 1'b0;
                    lvl_d = acc_d[SH +: 8];
                end
            end
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                acc_q <= 32'h0000_0000;
                cnt_q <= 32'h0000_0000;
                busy_q <= 1'b0;
                lvl_q <= 8'h00;
            end else begin
                acc_q <= acc_d;
                cnt_q <= cnt_d;
                busy_q <= busy_d;
                lvl_q <= lvl_d;
            end
        end
        assign int_busy[g] = busy_q;
        assign int_lvl[g] = lvl_q;
    end

    // --------
    // interrupt cause: set wins over clear
    // --------
    assign cause_d = psf_pkg::psf_cause_t'((cause_q & ~cause_clr_i) | ev);
    assign cause_o = cause_q;
    assign irq_o = |cause_q;

    // --------
    // core registers
    // --------
    always_ff @(posedge clk_i) begin
        if (tx_wr_i.en) begin
            tx_ram[tx_wr_i.addr] <= tx_wr_i.data;
        end
        if (ram_we) begin
            rx_ram[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_st_q <= psf_pkg::TX_IDLE;
            rx_st_q <= psf_pkg::RX_HUNT;
            {tx_cnt_q, tx_len_q, rx_cnt_q, rx_len_q, rx_lenf_q, zc_q} <= 42'h000_0000_0000;
            {tx_crc_q, rx_crc_q} <= 32'h0000_0000;
            {tx_strm_q, rx_strm_q, crc_ok_q, rxw_v_q} <= 4'h0;
            {rxw_q, rd_q, tx_hold_q} <= 24'h00_0000;
            fb_mem_q <= '{8'h00, 8'h00};
            {fb_wp_q, fb_rp_q, fb_cnt_q} <= 4'h0;
            {tx_req_q, tx_ack_s1, tx_ack_s2} <= 3'h0;
            {rx_tgl_s1, rx_tgl_s2, rx_tgl_s3} <= 3'h0;
            cause_q <= '0;
        end else begin
            tx_st_q <= tx_st_d;
            rx_st_q <= rx_st_d;
            {tx_cnt_q, tx_len_q, rx_cnt_q, rx_len_q, rx_lenf_q, zc_q} <=
                {tx_cnt_d, tx_len_d, rx_cnt_d, rx_len_d, rx_lenf_d, zc_d};
            {tx_crc_q, rx_crc_q} <= {tx_crc_d, rx_crc_d};
            {tx_strm_q, rx_strm_q, crc_ok_q, rxw_v_q} <= {tx_strm_d, rx_strm_d, crc_ok_d, rxw_v_d};
            {rxw_q, rd_q, tx_hold_q} <= {rxw_d, rx_ram[rx_rd_addr_i], tx_hold_d};
            fb_mem_q <= fb_mem_d;
            {fb_wp_q, fb_rp_q, fb_cnt_q} <= {fb_wp_d, fb_rp_d, fb_cnt_d};
            {tx_req_q, tx_ack_s1, tx_ack_s2} <= {tx_req_d, ltx_ack_q, tx_ack_s1};
            {rx_tgl_s1, rx_tgl_s2, rx_tgl_s3} <= {lrx_tgl_q, rx_tgl_s1, rx_tgl_s2};
            cause_q <= cause_d;
        end
    end

    assign tx_busy_o = tx_st_q != psf_pkg::TX_IDLE;
    assign rx_rd_data_o = rd_q;
    assign rx_word_o = rxw_q;
    assign rx_word_valid_o = rxw_v_q;
    assign rx_len_o = rx_len_q;
    assign crc_ok_o = crc_ok_q;
    assign lqi_o = int_lvl[0];
    assign cca_busy_o = int_busy[1];
    assign cca_level_o = int_lvl[1];

endmodule : psf_framer

`default_nettype wire

// File: bench/psf_checker.sv
// psf_checker: port assertions of the framer
`default_nettype none
module psf_checker #(
    parameter int CCA_CYCLES = 32
) (
    // core side
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [6:0] tx_len_i,
    input wire logic tx_go_i,
    input wire logic tx_busy_o,
    input wire logic rx_word_valid_o,
    input wire logic cca_busy_o,
    input wire psf_pkg::psf_cause_t cause_clr_i,
    input wire psf_pkg::psf_cause_t cause_o,
    input wire logic irq_o,
    // link side
    input wire logic link_clk_i,
    input wire logic [7:0] link_tx_data_o,
    input wire logic link_tx_valid_o,
    input wire logic link_tx_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // causes that must survive, and cycles of assessment so far
    psf_pkg::psf_cause_t keep_q, keep_d;
    int cnt_q, cnt_d;
    always_comb begin
        keep_d = cause_o & ~cause_clr_i;
        cnt_d = cca_busy_o ? cnt_q + 1 : 0;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            keep_q <= '0;
            cnt_q <= 0;
        end else begin
            keep_q <= keep_d;
            cnt_q <= cnt_d;
        end
    end
    irq_or_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_o == (|cause_o)) else $error("irq not the or of causes");
    cause_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cause_o & keep_q) == keep_q) else $error("cause lost without clear");
    go_busy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_go_i && !tx_busy_o && tx_len_i <= 7'h7d |=> tx_busy_o)
        else $error("transmit request not taken");
    long_go_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        tx_go_i && !tx_busy_o && tx_len_i > 7'h7d |=> !tx_busy_o)
        else $error("over-long transmit taken");
    busy_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(tx_busy_o) |-> ##[0:1] cause_o.tx_done) else $error("end without done");
    cca_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(cca_busy_o) |-> cnt_q == CCA_CYCLES) else $error("assessment length wrong");
    word_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_word_valid_o |=> !rx_word_valid_o) else $error("word valid too long");
    link_hold_a: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        link_tx_valid_o && !link_tx_ready_i |=> link_tx_valid_o && $stable(link_tx_data_o))
        else $error("link byte dropped before ready");
    tx_done_c: cover property (@(posedge clk_i) $rose(cause_o.tx_done));
    rx_done_c: cover property (@(posedge clk_i) $rose(cause_o.rx_done));
    cca_c: cover property (@(posedge clk_i) $fell(cca_busy_o));
endmodule : psf_checker
`default_nettype wire

// File: bench/psf_link_model.sv
// psf_link_model: far end of the link, sinks tx bytes and sends rx bytes
`default_nettype none
module psf_link_model (
    // link clock and reset
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    // framer transmit side
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // framer receive side
    output logic [7:0] rx_data_o,
    output logic rx_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic [1:0] cnt;
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
    end
    // when slow, ready only one link cycle in four
    always @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_ready_o <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (tx_valid_i && tx_ready_o)
                got.push_back(tx_data_i);
            cnt <= cnt + 2'h1;
            tx_ready_o <= !slow_i || cnt == 2'h3;
        end
    end
    // one pulse per byte, two link cycles apart; idle data is inverted
    task automatic send(input logic [7:0] b);
        @(posedge link_clk_i);
        rx_data_o <= b;
        rx_valid_o <= 1'b1;
        @(posedge link_clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask : send
endmodule : psf_link_model
`default_nettype wire

// File: bench/tb_top.sv
// tb_top: self-checking bench of the framer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, mode = 1'b0, go = 1'b0, slow = 1'b0;
    logic wvalid = 1'b0, cca = 1'b0, busy, wready, rx_wv, crc_ok, cca_busy, irq, ltv, ltr, lrv;
    logic [7:0] word = 8'h00, energy = 8'h40, rd_data, rx_word, lqi, cca_lvl, ltd, lrd;
    logic [6:0] len = 7'h00, rd_addr = 7'h00, rx_len;
    psf_pkg::psf_ram_wr_t wr = '0;
    psf_pkg::psf_cause_t clr = '0, cause;
    int n_mismatch = 0, cmp_count = 0;
    logic [7:0] words[$];
    always #2.5 clk = ~clk;
    initial begin
        #1.3;
        forever #40 lclk = ~lclk;
    end
    psf_framer #(.LQI_CYCLES(16), .CCA_CYCLES(32)) psf_framer_i (
        .clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk), .stream_mode_i(mode),
        .tx_wr_i(wr), .tx_len_i(len), .tx_go_i(go), .tx_busy_o(busy), .tx_word_i(word),
        .tx_word_valid_i(wvalid), .tx_word_ready_o(wready), .rx_rd_addr_i(rd_addr),
        .rx_rd_data_o(rd_data), .rx_word_o(rx_word), .rx_word_valid_o(rx_wv),
        .rx_len_o(rx_len), .crc_ok_o(crc_ok), .lqi_o(lqi), .energy_i(energy),
        .cca_start_i(cca), .cca_busy_o(cca_busy), .cca_level_o(cca_lvl),
        .cause_clr_i(clr), .cause_o(cause), .irq_o(irq), .link_tx_data_o(ltd),
        .link_tx_valid_o(ltv), .link_tx_ready_i(ltr), .link_rx_data_i(lrd),
        .link_rx_valid_i(lrv));
    psf_link_model psf_link_model_i (.link_clk_i(lclk), .rst_n_i(rst_n), .slow_i(slow),
        .tx_data_i(ltd), .tx_valid_i(ltv), .tx_ready_o(ltr), .rx_data_o(lrd), .rx_valid_o(lrv));
    always @(posedge clk) begin
        if (rx_wv === 1'b1)
            words.push_back(rx_word);
    end
    function automatic logic [7:0] pb(int i);
        return 8'h5a ^ 8'(i * 7);
    endfunction : pb
    function automatic logic [15:0] crc(int n);
        logic [15:0] c;
        logic [7:0] b;
        c = 16'h0000;
        for (int i = 0; i < n; i++) begin
            b = pb(i);
            for (int k = 0; k < 8; k++)
                c = (c[0] ^ b[k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        end
        return c;
    endfunction : crc
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // waits for a cause bit, then clears it with a one-cycle pulse
    task automatic wait_cause(int b);
        for (int k = 0; k < 20000 && cause[b] !== 1'b1; k++) @(negedge clk);
        chk("cause", 8'h01, 8'(cause[b]));
        clr[b] = 1'b1;
        @(negedge clk);
        clr = '0;
    endtask : wait_cause
    task automatic chk_frame(int n);
        logic [15:0] c;
        c = crc(n);
        chk("frame size", 8'(n + 8), 8'(psf_link_model_i.got.size()));
        for (int i = 0; i < n + 8 && i < psf_link_model_i.got.size(); i++)
            chk("frame byte", i < 4 ? 8'h00 : i == 4 ? 8'ha7 : i == 5 ? 8'(n + 2) :
                i < n + 6 ? pb(i - 6) : i == n + 6 ? c[7:0] : c[15:8],
                psf_link_model_i.got[i]);
        psf_link_model_i.got.delete();
    endtask : chk_frame
    task automatic go_pulse(int n);
        len = 7'(n);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask : go_pulse
    task automatic t_refuse();
        go_pulse(126);
        chk("busy", 8'h00, 8'(busy));
    endtask : t_refuse
    task automatic t_pkt_tx(int n);
        for (int i = 0; i < n; i++) begin
            wr = {1'b1, 7'(i), pb(i)};
            @(negedge clk);
        end
        wr = '0;
        go_pulse(n);
        chk("busy", 8'h01, 8'(busy));
        wait_cause(1);
        chk_frame(n);
    endtask : t_pkt_tx
    task automatic t_str_tx(int n);
        mode = 1'b1;
        go_pulse(n);
        for (int i = 0; i < n; i++) begin
            wait_cause(3);
            word = pb(i);
            wvalid = 1'b1;
            for (int k = 0; k < 2000 && wready !== 1'b1; k++) @(negedge clk);
            @(negedge clk);
            wvalid = 1'b0;
        end
        wait_cause(1);
        chk_frame(n);
        mode = 1'b0;
    endtask : t_str_tx
    task automatic send_frame(int n, logic [15:0] c);
        for (int i = 0; i < 4; i++)
            psf_link_model_i.send(8'h00);
        psf_link_model_i.send(8'ha7);
        psf_link_model_i.send(8'(n + 2));
        for (int i = 0; i < n; i++)
            psf_link_model_i.send(pb(i));
        psf_link_model_i.send(c[7:0]);
        psf_link_model_i.send(c[15:8]);
    endtask : send_frame
    task automatic t_pkt_rx(int n, logic bad);
        logic [15:0] c;
        c = crc(n) ^ {15'h0000, bad};
        send_frame(n, c);
        wait_cause(0);
        chk("length", 8'(n), 8'(rx_len));
        chk("check ok", 8'(!bad), 8'(crc_ok));
        chk("lqi", energy, lqi);
        chk("word count", 8'h00, 8'(words.size()));
        for (int i = 0; i < n + 2; i++) begin
            rd_addr = 7'(i);
            @(negedge clk);
            chk("ram", i < n ? pb(i) : i == n ? c[7:0] : c[15:8], rd_data);
        end
    endtask : t_pkt_rx
    task automatic t_str_rx(int n);
        mode = 1'b1;
        send_frame(n, crc(n));
        for (int k = 0; k < 2000 && words.size() < n; k++) @(negedge clk);
        chk("word count", 8'(n), 8'(words.size()));
        foreach (words[i])
            chk("word", pb(i), words[i]);
        wait_cause(2);
        mode = 1'b0;
    endtask : t_str_rx
    task automatic t_cca();
        cca = 1'b1;
        @(negedge clk);
        cca = 1'b0;
        for (int k = 0; k < 200 && cca_busy !== 1'b0; k++) @(negedge clk);
        chk("level", energy, cca_lvl);
    endtask : t_cca
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("irq", 8'h00, 8'(irq));
        t_refuse();
        slow = 1'b1;
        t_pkt_tx(5);
        slow = 1'b0;
        t_pkt_tx(0);
        t_str_tx(3);
        t_pkt_rx(4, 1'b0);
        t_pkt_rx(125, 1'b1);
        t_str_rx(3);
        t_cca();
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
bind psf_framer psf_checker #(.CCA_CYCLES(CCA_CYCLES)) psf_checker_i (.clk_i, .rst_n_i,
    .tx_len_i, .tx_go_i, .tx_busy_o, .rx_word_valid_o, .cca_busy_o, .cause_clr_i, .cause_o,
    .irq_o, .link_clk_i, .link_tx_data_o, .link_tx_valid_o, .link_tx_ready_i);
`default_nettype wire
